// file: hw/low_power_clock_gating_bank0.sv
// Sleep and deep-sleep clock gating bank with AXI4-Lite register access
// Overview of operation
// R1: Each gating bit is one unit's clock enable
// R2: Access to a gated-off unit raises bus fault; only the converter and watchdog have a fault path here
// R3: Sleep and deep-sleep registers reset to 0x40
// R4: Other gating bits reset to zero, unit unclocked
// R5: Run, sleep, deep-sleep registers apply per mode
// R6: Sleep registers act only with auto gating set
// R7: Bit 16 gates converter clock; access faults
// R8: Bits 9:8 select converter sample rate
// R9: Sample rate never exceeds the part maximum
// R10: Bit 6 gates the hibernation unit clock
// R11: Bit 3 gates watchdog clock; access faults
// R12: Reserved bits read zero, ignore writes
// R13: Sleep register at 0x110, deep at 0x120
// R14: Software enables the units it needs
// R15: Without auto gating, run settings stay applied
`timescale 1ns/10ps
`include "clock_gate_cfg.svh"
module low_power_clock_gating_bank0 #(
   parameter logic [1:0] MAX_RATE_CODE = `RATE_500K   // Fastest rate the part allows
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // AXI4-Lite write channels
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   output logic [1:0]       S_AXI_BRESP,
   // AXI4-Lite read channels
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   // Power mode requests from the processor
   input  wire logic        SLEEP_REQ,
   input  wire logic        DEEP_SLEEP_REQ,
   // Unit access strobes from the system bus decoder
   input  wire logic        ADC_ACCESS,
   input  wire logic        WDT_ACCESS,
   // Unit clock enables and converter rate
   output logic             ADC_CLK_EN,
   output logic             HIB_CLK_EN,
   output logic             WDT_CLK_EN,
   output logic [1:0]       ADC_RATE,
   // Faults and interrupt
   output logic             ADC_BUS_FAULT,
   output logic             WDT_BUS_FAULT,
   output logic             IRQ
);
   import clock_gate_pkg::*;

   localparam logic [31:0] GATE_RST = `GATE_RESET;   // Reset image of a gating word

   bank_state_s st_q;          // Registered bank state
   bank_state_s st_d;          // Next bank state
   logic        wr_en;         // Write strobe from the port
   logic [11:0] wr_addr;       // Write byte address
   logic [31:0] wr_data;       // Write data
   logic [3:0]  wr_strb;       // Write byte strobes
   logic        wr_err;        // Write hits no register
   logic        rd_en;         // Read strobe from the port
   logic [11:0] rd_addr;       // Read byte address
   logic [31:0] rd_data;       // Read word
   logic        rd_err;        // Read hits no register
   power_mode_e mode_req;      // Mode asked for this cycle

   // Limit a rate code to the part maximum; code 3 is also pulled down
   function automatic logic [1:0] clamp_rate(input logic [1:0] code);
      clamp_rate = (code > MAX_RATE_CODE) ? MAX_RATE_CODE : code;   // R9
   endfunction : clamp_rate

   // Unpack a gating word into its stored fields
   function automatic gate_fields_s unpack_gate(input logic [31:0] w);
      gate_fields_s f;
      f.adc_en = w[`ADC_EN_BIT];                          // R7
      f.rate   = clamp_rate(w[`RATE_MSB:`RATE_LSB]);      // R8
      f.hib_en = w[`HIB_EN_BIT];                          // R10
      f.wdt_en = w[`WDT_EN_BIT];                          // R11
      unpack_gate = f;
   endfunction : unpack_gate

   // Pack stored fields into a word; reserved bits come back as zero
   function automatic logic [31:0] pack_gate(input gate_fields_s f);
      logic [31:0] w;
      w                       = 32'h00000000;             // R12
      w[`ADC_EN_BIT]          = f.adc_en;
      w[`RATE_MSB:`RATE_LSB]  = f.rate;
      w[`HIB_EN_BIT]          = f.hib_en;
      w[`WDT_EN_BIT]          = f.wdt_en;
      pack_gate = w;
   endfunction : pack_gate

   // Byte-lane merge of new write data over an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] w;
      w = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            w[8*i +: 8] = data[8*i +: 8];
         end
      end
      merge = w;
   endfunction : merge

   // Apply a bus write to one gating register
   function automatic gate_fields_s write_gate(input gate_fields_s old, input logic [31:0] data,
                                               input logic [3:0] strb);
      write_gate = unpack_gate(merge(pack_gate(old), data, strb));
   endfunction : write_gate

   // True when the address names one of the bank's registers
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `RUN_GATE_OFS) || (a == `SLEEP_GATE_OFS) || (a == `DEEP_GATE_OFS) ||
                  (a == `CLOCK_CONFIG_OFS) || (a == `EVENT_STATUS_OFS) ||
                  (a == `EVENT_MASK_OFS);   // R13
   endfunction : is_mapped

   // Bus front end
   axil_reg_port u_port (
      .clk           (SYS_CLK),
      .rst_n         (RST_N),
      .s_axi_awvalid (S_AXI_AWVALID),
      .s_axi_awready (S_AXI_AWREADY),
      .s_axi_awaddr  (S_AXI_AWADDR),
      .s_axi_wvalid  (S_AXI_WVALID),
      .s_axi_wready  (S_AXI_WREADY),
      .s_axi_wdata   (S_AXI_WDATA),
      .s_axi_wstrb   (S_AXI_WSTRB),
      .s_axi_bvalid  (S_AXI_BVALID),
      .s_axi_bready  (S_AXI_BREADY),
      .s_axi_bresp   (S_AXI_BRESP),
      .s_axi_arvalid (S_AXI_ARVALID),
      .s_axi_arready (S_AXI_ARREADY),
      .s_axi_araddr  (S_AXI_ARADDR),
      .s_axi_rvalid  (S_AXI_RVALID),
      .s_axi_rready  (S_AXI_RREADY),
      .s_axi_rdata   (S_AXI_RDATA),
      .s_axi_rresp   (S_AXI_RRESP),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_err        (wr_err),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_err        (rd_err)
   );

   // Unmapped addresses answer with a slave error
   assign wr_err = !is_mapped(wr_addr);
   assign rd_err = !is_mapped(rd_addr);

   // Read multiplexer; rd_en only qualifies the capture in the port
   always_comb begin
      case (rd_addr)
         `RUN_GATE_OFS:     rd_data = pack_gate(st_q.run);
         `SLEEP_GATE_OFS:   rd_data = pack_gate(st_q.sleep);     // R13
         `DEEP_GATE_OFS:    rd_data = pack_gate(st_q.deep);      // R13
         `CLOCK_CONFIG_OFS: rd_data = {31'h00000000, st_q.auto_gate};
         `EVENT_STATUS_OFS: rd_data = {29'h00000000, st_q.status};
         `EVENT_MASK_OFS:   rd_data = {29'h00000000, st_q.mask};
         default:           rd_data = 32'h00000000;
      endcase
   end

   // Requested mode; deep sleep outranks sleep
   assign mode_req = DEEP_SLEEP_REQ ? MODE_DEEP : (SLEEP_REQ ? MODE_SLEEP : MODE_RUN);

   // Next-state logic of the whole bank
   always_comb begin
      logic [`EVT_WIDTH-1:0] evt_set;   // Events raised this cycle
      logic [`EVT_WIDTH-1:0] evt_clr;   // Write-one-to-clear bits
      evt_set = '0;
      evt_clr = '0;
      st_d    = st_q;
      st_d.post_rst = 1'b1;
      // Register writes
      if (wr_en) begin
         case (wr_addr)
            `RUN_GATE_OFS: begin
               st_d.run = write_gate(st_q.run, wr_data, wr_strb);
            end
            `SLEEP_GATE_OFS: begin
               st_d.sleep = write_gate(st_q.sleep, wr_data, wr_strb);   // R13
            end
            `DEEP_GATE_OFS: begin
               st_d.deep = write_gate(st_q.deep, wr_data, wr_strb);     // R13
            end
            `CLOCK_CONFIG_OFS: begin
               if (wr_strb[0]) begin
                  st_d.auto_gate = wr_data[`AUTO_GATE_BIT];             // R6
               end
            end
            `EVENT_STATUS_OFS: begin
               if (wr_strb[0]) begin
                  evt_clr = wr_data[`EVT_WIDTH-1:0];
               end
            end
            `EVENT_MASK_OFS: begin
               if (wr_strb[0]) begin
                  st_d.mask = wr_data[`EVT_WIDTH-1:0];
               end
            end
            default: begin
               // Unmapped write changes nothing
            end
         endcase
      end
      // Mode tracking; a change is a transition event
      st_d.mode = mode_req;
      evt_set[`EVT_MODE_CHANGE] = (mode_req != st_q.mode);
      // Source of the applied enables follows the registered mode
      case (st_q.mode)
         MODE_SLEEP: st_d.applied = st_q.auto_gate ? st_q.sleep : st_q.run;   // R5 R6 R15
         MODE_DEEP:  st_d.applied = st_q.auto_gate ? st_q.deep : st_q.run;    // R5 R6 R15
         MODE_RUN:   st_d.applied = st_q.run;                                 // R5
         default:    st_d.applied = st_q.run;
      endcase
      // Accesses to an unclocked unit fault; the hibernation unit has no fault path
      st_d.fault_adc = ADC_ACCESS && !st_q.applied.adc_en;   // R2 R7
      st_d.fault_wdt = WDT_ACCESS && !st_q.applied.wdt_en;   // R2 R11
      evt_set[`EVT_ADC_FAULT] = st_d.fault_adc;
      evt_set[`EVT_WDT_FAULT] = st_d.fault_wdt;
      // Set beats clear so an event in the clearing cycle survives
      st_d.status = (st_q.status & ~evt_clr) | evt_set;
      st_d.irq    = |(st_d.status & st_d.mask);
   end

   // State register; every gating word leaves reset at the documented image
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q          <= '0;
         st_q.run      <= '{adc_en: GATE_RST[`ADC_EN_BIT], rate: GATE_RST[`RATE_MSB:`RATE_LSB],
                            hib_en: GATE_RST[`HIB_EN_BIT], wdt_en: GATE_RST[`WDT_EN_BIT]};
         st_q.sleep    <= '{adc_en: GATE_RST[`ADC_EN_BIT], rate: GATE_RST[`RATE_MSB:`RATE_LSB],
                            hib_en: GATE_RST[`HIB_EN_BIT], wdt_en: GATE_RST[`WDT_EN_BIT]}; // R3 R4
         st_q.deep     <= '{adc_en: GATE_RST[`ADC_EN_BIT], rate: GATE_RST[`RATE_MSB:`RATE_LSB],
                            hib_en: GATE_RST[`HIB_EN_BIT], wdt_en: GATE_RST[`WDT_EN_BIT]}; // R3 R4
         st_q.applied  <= '{adc_en: GATE_RST[`ADC_EN_BIT], rate: GATE_RST[`RATE_MSB:`RATE_LSB],
                            hib_en: GATE_RST[`HIB_EN_BIT], wdt_en: GATE_RST[`WDT_EN_BIT]};
         st_q.mode     <= MODE_RUN;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs, all straight from flops
   assign ADC_CLK_EN    = st_q.applied.adc_en;   // R1 R7
   assign HIB_CLK_EN    = st_q.applied.hib_en;   // R1 R10
   assign WDT_CLK_EN    = st_q.applied.wdt_en;   // R1 R11
   assign ADC_RATE      = st_q.applied.rate;     // R8
   assign ADC_BUS_FAULT = st_q.fault_adc;
   assign WDT_BUS_FAULT = st_q.fault_wdt;
   assign IRQ           = st_q.irq;

   // Checks on the bank's behaviour
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   AST_RESET_IMAGE: assert property ( // R3 R4
      !st_q.post_rst |-> pack_gate(st_q.sleep) == `GATE_RESET &&
                         pack_gate(st_q.deep) == `GATE_RESET && HIB_CLK_EN && !ADC_CLK_EN)
      else $error("Gating registers left reset with a wrong value");

   AST_ADC_FAULT: assert property ( // R2 R7
      ADC_ACCESS && !ADC_CLK_EN |=> ADC_BUS_FAULT ##1 !$rose(ADC_BUS_FAULT))
      else $error("Access to unclocked converter did not fault");

   AST_ADC_NO_FAULT: assert property ( // R2
      ADC_ACCESS && ADC_CLK_EN |=> !ADC_BUS_FAULT)
      else $error("Access to clocked converter faulted");

   AST_WDT_FAULT: assert property ( // R11
      WDT_ACCESS && !WDT_CLK_EN |=> WDT_BUS_FAULT && st_q.status[`EVT_WDT_FAULT])
      else $error("Access to unclocked watchdog did not fault");

   AST_RATE_LIMIT: assert property ( // R9
      ADC_RATE <= MAX_RATE_CODE && st_q.sleep.rate <= MAX_RATE_CODE)
      else $error("Converter rate above the part maximum");

   AST_SLEEP_WRITE: assert property ( // R8 R13
      wr_en && wr_addr == `SLEEP_GATE_OFS && wr_strb[1]
      |=> st_q.sleep.rate == clamp_rate($past(wr_data[`RATE_MSB:`RATE_LSB])))
      else $error("Sleep rate field did not take the written code");

   AST_MODE_APPLY: assert property ( // R5 R10
      st_q.auto_gate && st_q.mode == MODE_SLEEP
      |=> HIB_CLK_EN == $past(st_q.sleep.hib_en) && WDT_CLK_EN == $past(st_q.sleep.wdt_en))
      else $error("Sleep settings not applied in sleep mode");

   AST_RUN_HOLDS: assert property ( // R6 R15
      !st_q.auto_gate
      |=> ADC_CLK_EN == $past(st_q.run.adc_en) && ADC_RATE == $past(st_q.run.rate))
      else $error("Run settings not kept without auto gating");

   AST_RESERVED_ZERO: assert property ( // R12
      (rd_addr == `SLEEP_GATE_OFS || rd_addr == `DEEP_GATE_OFS)
      |-> (rd_data & ~`GATE_WRITABLE) == 32'h00000000)
      else $error("Reserved bits read non-zero");

   AST_IRQ_LEVEL: assert property (
      |(st_q.status & st_q.mask) |-> IRQ)
      else $error("Interrupt low with an unmasked event pending");

   COV_DEEP_APPLIED: cover property (st_q.auto_gate && st_q.mode == MODE_DEEP ##1 !ADC_CLK_EN);
   COV_WDT_FAULT:    cover property (WDT_ACCESS && !WDT_CLK_EN ##1 WDT_BUS_FAULT ##1 IRQ);
   COV_RATE_CLAMP:   cover property (wr_en && wr_addr == `SLEEP_GATE_OFS &&
                                     wr_data[`RATE_MSB:`RATE_LSB] > MAX_RATE_CODE);

endmodule : low_power_clock_gating_bank0

// file: hw/clock_gate_cfg.svh
// Register offsets, field positions, reset values and answer codes of the sleep gating bank
`ifndef CLOCK_GATE_CFG_SVH
`define CLOCK_GATE_CFG_SVH

// Register byte offsets inside the system control block
`define RUN_GATE_OFS       12'h100
`define SLEEP_GATE_OFS     12'h110
`define DEEP_GATE_OFS      12'h120
`define CLOCK_CONFIG_OFS   12'h130
`define EVENT_STATUS_OFS   12'h140
`define EVENT_MASK_OFS     12'h144

// Field positions of a gating word and of the clock configuration register
`define ADC_EN_BIT         16
`define RATE_MSB           9
`define RATE_LSB           8
`define HIB_EN_BIT         6
`define WDT_EN_BIT         3
`define AUTO_GATE_BIT      0

// Reset value and writable bits of a gating word
`define GATE_RESET         32'h00000040
`define GATE_WRITABLE      32'h00010348

// Sample rate codes
`define RATE_500K          2'h2
`define RATE_250K          2'h1
`define RATE_125K          2'h0

// Event bits of the status and mask registers
`define EVT_ADC_FAULT      0
`define EVT_WDT_FAULT      1
`define EVT_MODE_CHANGE    2
`define EVT_WIDTH          3

// Bus answer codes
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// file: hw/clock_gate_pkg.sv
// Types shared by the sleep gating bank and its register port
package clock_gate_pkg;
`include "clock_gate_cfg.svh"

   // Applied power mode, Gray coded along run, sleep, deep sleep
   typedef enum logic [1:0] {
      MODE_RUN   = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_DEEP  = 2'b11
   } power_mode_e;

   // Stored fields of one gating word
   typedef struct packed {
      logic       adc_en;
      logic [1:0] rate;
      logic       hib_en;
      logic       wdt_en;
   } gate_fields_s;

   // Whole state of the gating bank
   typedef struct packed {
      gate_fields_s            run;
      gate_fields_s            sleep;
      gate_fields_s            deep;
      logic                    auto_gate;
      power_mode_e             mode;
      gate_fields_s            applied;
      logic [`EVT_WIDTH-1:0]   status;
      logic [`EVT_WIDTH-1:0]   mask;
      logic                    fault_adc;
      logic                    fault_wdt;
      logic                    irq;
      logic                    post_rst;
   } bank_state_s;

   // Whole state of the register port
   typedef struct packed {
      logic        aw_have;
      logic [11:0] aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } port_state_s;

endpackage : clock_gate_pkg

// file: hw/axil_reg_port.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/10ps
`include "clock_gate_cfg.svh"
module axil_reg_port (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Write address and data channels
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // Write response channel
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // Read channels
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [11:0] s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Register side
   output logic             wr_en,
   output logic [11:0]      wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_err,
   output logic             rd_en,
   output logic [11:0]      rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_err
);
   import clock_gate_pkg::*;

   port_state_s s_q;   // Registered port state
   port_state_s s_d;   // Next port state

   // Each write channel holds one item until the write pair is answered; the read address channel waits only for the read answer
   assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
   assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign wr_addr       = s_q.aw_addr;
   assign wr_data       = s_q.w_data;
   assign wr_strb       = s_q.w_strb;
   assign rd_addr       = s_axi_araddr;

   // Channel bookkeeping; address and data may come in either order
   always_comb begin
      s_d   = s_q;
      wr_en = 1'b0;
      rd_en = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // Both halves held: commit the write and answer next cycle
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         wr_en       = 1'b1;
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      // Read data is captured in the cycle the address is taken
      if (s_axi_arvalid && s_axi_arready) begin
         rd_en      = 1'b1;
         s_d.rvalid = 1'b1;
         s_d.rdata  = rd_data;
         s_d.rresp  = rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : axil_reg_port

// file: test/test_low_power_clock_gating_bank0.sv
// Self-checking bench for the sleep and deep-sleep clock gating bank
`timescale 1ns/10ps
`include "clock_gate_cfg.svh"
module test_low_power_clock_gating_bank0;
   // Bench-driven inputs
   logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic        sleep_req, deep_req, adc_acc, wdt_acc;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   // Design outputs
   logic        awready, wready, bvalid, arready, rvalid, adc_en, hib_en, wdt_en;
   logic        adc_flt, wdt_flt, irq;
   logic [1:0]  bresp, rresp, rate;
   logic [31:0] rdata;
   // Scratch results and counters
   logic [1:0]  resp;
   logic [31:0] data;
   int          n_fail, n_tests, cycles;
   // One table row: address, value written, value read back, answer code
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wval;
      logic [31:0] rval;
      logic [1:0]  code;
   } row_s;
   row_s        rows [5];

   // Device under test
   low_power_clock_gating_bank0 low_power_clock_gating_bank0_i (
      .SYS_CLK(sys_clk), .RST_N(rst_n),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .SLEEP_REQ(sleep_req),
      .DEEP_SLEEP_REQ(deep_req), .ADC_ACCESS(adc_acc), .WDT_ACCESS(wdt_acc),
      .ADC_CLK_EN(adc_en), .HIB_CLK_EN(hib_en), .WDT_CLK_EN(wdt_en),
      .ADC_RATE(rate), .ADC_BUS_FAULT(adc_flt), .WDT_BUS_FAULT(wdt_flt), .IRQ(irq)
   );

   // Verdict and end of run
   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done

   // Compare one result; an unknown bit matches only an unknown expected bit
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Bus write: both halves offered together, each released once taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_t, w_t, b_t;
      @(posedge sys_clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      b_t = 1'b0;
      // Sample just after the edge, where ready has settled for the next edge
      while (!b_t) begin
         #1;
         aw_t = awvalid && (awready === 1'b1);
         w_t = wvalid && (wready === 1'b1);
         b_t = (bvalid === 1'b1);
         r = bresp;
         @(posedge sys_clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) bready <= 1'b0;
      end
   endtask : axi_wr

   // Bus read: address held until taken, data taken at the answer edge
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_t, r_t;
      @(posedge sys_clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      r_t = 1'b0;
      while (!r_t) begin
         #1;
         ar_t = arvalid && (arready === 1'b1);
         r_t = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge sys_clk);
         if (ar_t) arvalid <= 1'b0;
         if (r_t) rready <= 1'b0;
      end
   endtask : axi_rd

   // Write expecting a plain acceptance
   task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
      axi_wr(a, d, resp);
      chk("bresp", `RESP_OKAY, resp);
   endtask : wr_ok

   // Read expecting a given word
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      axi_rd(a, data, resp);
      chk("rresp", `RESP_OKAY, resp);
      chk("rdata", e, data);
   endtask : rd_chk

   // Let n edges pass, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // Unit enables and converter rate
   task automatic en_chk(input logic a, input logic h, input logic w, input logic [1:0] r);
      chk("adc enable", a, adc_en);
      chk("hib enable", h, hib_en);
      chk("wdt enable", w, wdt_en);
      chk("rate", r, rate);
   endtask : en_chk

   // One access strobe to both units, then faults and interrupt
   task automatic pulse(input logic e);
      @(posedge sys_clk);
      adc_acc <= 1'b1;
      wdt_acc <= 1'b1;
      @(posedge sys_clk);
      adc_acc <= 1'b0;
      wdt_acc <= 1'b0;
      #1;
      chk("adc fault", e, adc_flt);
      chk("wdt fault", e, wdt_flt);
      chk("irq", e, irq);
   endtask : pulse

   // Free-running 125 MHz clock
   always #4 sys_clk = ~sys_clk;

   // Cut a hung run short; the sequence needs well under 1000 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         test_done();
      end
   end

   // Main sequence
   initial begin
      sys_clk = 1'b0;
      {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {sleep_req, deep_req, adc_acc, wdt_acc, awaddr, araddr, wdata} = '0;
      {n_fail, n_tests, cycles} = '0;
      wstrb = 4'hf;
      // Rate code 3 is stored clamped; reserved bits read zero
      rows = '{'{`SLEEP_GATE_OFS, 32'hffffffff, 32'h00010248, `RESP_OKAY},
               '{`DEEP_GATE_OFS, 32'h00000108, 32'h00000108, `RESP_OKAY},
               '{`DEEP_GATE_OFS, 32'h00000200, 32'h00000200, `RESP_OKAY},
               '{`SLEEP_GATE_OFS, 32'h00000000, 32'h00000000, `RESP_OKAY},
               '{12'h204, 32'h00000001, 32'h00000000, `RESP_SLVERR}};
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      tick(1);
      en_chk(1'b0, 1'b1, 1'b0, 2'h0);
      rd_chk(`SLEEP_GATE_OFS, `GATE_RESET);
      rd_chk(`DEEP_GATE_OFS, `GATE_RESET);
      foreach (rows[i]) begin
         axi_wr(rows[i].addr, rows[i].wval, resp);
         chk("bresp", rows[i].code, resp);
         axi_rd(rows[i].addr, data, resp);
         chk("rresp", rows[i].code, resp);
         chk("rdata", rows[i].rval, data);
      end
      // Running: the run register drives the enables
      wr_ok(`RUN_GATE_OFS, 32'h00010108);
      tick(4);
      en_chk(1'b1, 1'b0, 1'b1, 2'h1);
      // Both requests high, deep wins; without automatic gating run stays
      wr_ok(`DEEP_GATE_OFS, 32'h00000240);
      @(posedge sys_clk);
      deep_req <= 1'b1;
      sleep_req <= 1'b1;
      tick(4);
      en_chk(1'b1, 1'b0, 1'b1, 2'h1);
      wr_ok(`CLOCK_CONFIG_OFS, 32'h00000001);
      tick(4);
      en_chk(1'b0, 1'b1, 1'b0, 2'h2);
      @(posedge sys_clk);
      deep_req <= 1'b0;
      tick(4);
      en_chk(1'b0, 1'b0, 1'b0, 2'h0);
      // Gated units fault; status is sticky and cleared by writing ones
      wr_ok(`EVENT_MASK_OFS, 32'h00000003);
      pulse(1'b1);
      rd_chk(`EVENT_STATUS_OFS, 32'h00000007);
      wr_ok(`EVENT_STATUS_OFS, 32'h00000007);
      tick(2);
      chk("irq", 1'b0, irq);
      // Back to running: clocked units take access without fault
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      tick(4);
      pulse(1'b0);
      // Low byte lane only: the rate and converter bits keep their stored values
      @(posedge sys_clk);
      wstrb <= 4'h1;
      wr_ok(`SLEEP_GATE_OFS, 32'hffffffff);
      rd_chk(`SLEEP_GATE_OFS, 32'h00000048);
      test_done();
   end
endmodule : test_low_power_clock_gating_bank0
